// ==== hdl/ebm_mode_decode.sv ====
/*
  Mode decoder: turns the captured mode into the port function assignment.
  Assumes the mode is stable after reset release.
*/
`timescale 1ns/10ps
module ebm_mode_decode (
  // Mode in.
  input wire ebm_pkg::ebm_mode_t mode,
  input wire logic [7:0] ctrl,
  // Assignment out.
  output ebm_pkg::ebm_portcfg_t cfg
);

  // Decode mode and, where protection is lifted, the control overrides.
  always_comb begin
    cfg = '0;
    cfg.cpu_active = 1'b1;
    unique case (mode)
      ebm_pkg::EBM_NORMAL_WIDE, ebm_pkg::EBM_EMUL_WIDE: begin
        cfg.bus_en = 1'b1;
        cfg.wide = 1'b1;
      end
      ebm_pkg::EBM_NORMAL_NARROW, ebm_pkg::EBM_EMUL_NARROW: begin
        cfg.bus_en = 1'b1;
      end
      ebm_pkg::EBM_NORMAL_SINGLE: begin
        cfg.bus_en = 1'b0;
      end
      ebm_pkg::EBM_SPECIAL_SINGLE: begin
        cfg.bdm_active = 1'b1;
      end
      ebm_pkg::EBM_SPECIAL_TEST: begin
        cfg.prot_lifted = 1'b1;
        cfg.bus_en = ~ctrl[ebm_pkg::EBM_CTRL_BUSEN_BIT];
        cfg.wide = ~ctrl[ebm_pkg::EBM_CTRL_WIDE_BIT];
      end
      ebm_pkg::EBM_SPECIAL_PERIPH: begin
        cfg.cpu_active = 1'b0;
        cfg.ext_master = 1'b1;
        cfg.bus_en = 1'b1;
        cfg.wide = 1'b1;
      end
    endcase
  end

endmodule

// ==== hdl/ebm_top.sv ====
/*
  External bus mode port configuration: mode capture, port function assignment,
  multiplexed address/data bus sequencing and general-purpose port registers.
  Assumes inputs synchronous to clk_sys and a one-request-at-a-time core.
*/
// Local design decision: strobed register access.
`timescale 1ns/10ps
module ebm_top (
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Mode strap pins.
  input wire logic [2:0] mode_pins,
  // Register port.
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Core bus request.
  input wire ebm_pkg::ebm_req_t core_req,
  output logic core_ack,
  output logic [15:0] core_rdata,
  // Port pins, enables low while driving.
  input wire logic [7:0] port_a_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_in,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe_n,
  input wire logic [7:0] port_e_in,
  output logic [7:0] port_e_out,
  output logic [7:0] port_e_oe_n,
  input wire logic [7:0] port_k_in,
  output logic [7:0] port_k_out,
  output logic [7:0] port_k_oe_n,
  // Mode status.
  output logic cpu_active,
  output logic background_debug_mode
);

  ebm_pkg::ebm_mode_t mode_reg;
  logic captured_reg;
  logic [7:0] ctrl_reg;
  logic [7:0] gpio_a_reg, gpio_b_reg, gpio_e_reg, gpio_k_reg;
  logic [7:0] ddr_a_reg, ddr_b_reg, ddr_e_reg, ddr_k_reg;
  ebm_pkg::ebm_portcfg_t cfg;
  ebm_pkg::ebm_phase_t phase_reg;
  ebm_pkg::ebm_req_t req_reg;
  logic [7:0] a_out_next, b_out_next, e_out_next;
  logic [7:0] a_oe_next, b_oe_next, e_oe_next;

  ebm_mode_decode u_dec (
    .mode(mode_reg),
    .ctrl(ctrl_reg),
    .cfg(cfg)
  );

  // Register write strobe to a given offset.
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] off, input logic w);
    wr_hit = w && (a == off);
  endfunction

  // mode capture at release
  // The strap is sampled on the first edge after reset is released.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      captured_reg <= 1'b0;
      mode_reg <= ebm_pkg::EBM_SPECIAL_SINGLE;
    end else if (!captured_reg) begin
      captured_reg <= 1'b1;
      mode_reg <= ebm_pkg::ebm_mode_t'(mode_pins);
    end
  end

  // protection lifted in test
  // The control register takes writes only in special test mode.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_reg <= ebm_pkg::EBM_RST_BYTE;
    end else if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_CTRL, reg_wr) && cfg.prot_lifted) begin
      ctrl_reg <= reg_wdata;
    end
  end

  // GPIO data and direction
  // General-purpose data and direction registers, written anytime.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      gpio_a_reg <= ebm_pkg::EBM_RST_BYTE;
      gpio_b_reg <= ebm_pkg::EBM_RST_BYTE;
      gpio_e_reg <= ebm_pkg::EBM_RST_BYTE;
      gpio_k_reg <= ebm_pkg::EBM_RST_BYTE;
      ddr_a_reg <= ebm_pkg::EBM_RST_BYTE;
      ddr_b_reg <= ebm_pkg::EBM_RST_BYTE;
      ddr_e_reg <= ebm_pkg::EBM_RST_BYTE;
      ddr_k_reg <= ebm_pkg::EBM_RST_BYTE;
    end else begin
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_GPIO_A, reg_wr)) gpio_a_reg <= reg_wdata;
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_GPIO_B, reg_wr)) gpio_b_reg <= reg_wdata;
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_GPIO_E, reg_wr)) gpio_e_reg <= reg_wdata;
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_GPIO_K, reg_wr)) gpio_k_reg <= reg_wdata;
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_DDR_A, reg_wr)) ddr_a_reg <= reg_wdata;
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_DDR_B, reg_wr)) ddr_b_reg <= reg_wdata;
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_DDR_E, reg_wr)) ddr_e_reg <= reg_wdata;
      if (wr_hit(reg_addr, ebm_pkg::EBM_OFF_DDR_K, reg_wr)) ddr_k_reg <= reg_wdata;
    end
  end

  // Read data stand in the cycle after the read strobe only.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= ebm_pkg::EBM_RST_BYTE;
    end else if (!reg_rd) begin
      reg_rdata <= ebm_pkg::EBM_RST_BYTE;
    end else begin
      unique case (reg_addr)
        ebm_pkg::EBM_OFF_MODE: reg_rdata <= {5'h00, mode_reg};
        ebm_pkg::EBM_OFF_CTRL: reg_rdata <= ctrl_reg;
        ebm_pkg::EBM_OFF_GPIO_A: reg_rdata <= (gpio_a_reg & ddr_a_reg) | (port_a_in & ~ddr_a_reg);
        ebm_pkg::EBM_OFF_GPIO_B: reg_rdata <= (gpio_b_reg & ddr_b_reg) | (port_b_in & ~ddr_b_reg);
        ebm_pkg::EBM_OFF_GPIO_E: reg_rdata <= (gpio_e_reg & ddr_e_reg) | (port_e_in & ~ddr_e_reg);
        ebm_pkg::EBM_OFF_GPIO_K: reg_rdata <= (gpio_k_reg & ddr_k_reg) | (port_k_in & ~ddr_k_reg);
        ebm_pkg::EBM_OFF_DDR_A: reg_rdata <= ddr_a_reg;
        ebm_pkg::EBM_OFF_DDR_B: reg_rdata <= ddr_b_reg;
        ebm_pkg::EBM_OFF_DDR_E: reg_rdata <= ddr_e_reg;
        ebm_pkg::EBM_OFF_DDR_K: reg_rdata <= ddr_k_reg;
        default: reg_rdata <= ebm_pkg::EBM_RSVD_READ;
      endcase
    end
  end

  // bus cycle sequencing
  // Address phase, then one data phase (wide) or two byte phases (narrow).
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      phase_reg <= ebm_pkg::EBM_PH_IDLE;
      req_reg <= '0;
      core_ack <= 1'b0;
      core_rdata <= 16'h0000;
    end else begin
      core_ack <= 1'b0;
      unique case (phase_reg)
        ebm_pkg::EBM_PH_IDLE: begin
          if (core_req.valid && cfg.bus_en && cfg.cpu_active && captured_reg) begin
            req_reg <= core_req;
            phase_reg <= ebm_pkg::EBM_PH_ADDR;
          end
        end
        ebm_pkg::EBM_PH_ADDR: begin
          phase_reg <= ebm_pkg::EBM_PH_DATA;
        end
        ebm_pkg::EBM_PH_DATA: begin
          if (cfg.wide) begin
            core_rdata <= {port_a_in, port_b_in};
            core_ack <= 1'b1;
            phase_reg <= ebm_pkg::EBM_PH_IDLE;
          end else begin
            core_rdata[15:8] <= port_a_in;
            phase_reg <= ebm_pkg::EBM_PH_DATA_LO;
          end
        end
        ebm_pkg::EBM_PH_DATA_LO: begin
          core_rdata[7:0] <= port_a_in;
          core_ack <= 1'b1;
          phase_reg <= ebm_pkg::EBM_PH_IDLE;
        end
      endcase
    end
  end

  // Pin drive decided per mode and bus phase.
  always_comb begin
    a_out_next = gpio_a_reg;
    b_out_next = gpio_b_reg;
    e_out_next = gpio_e_reg;
    a_oe_next = ~ddr_a_reg;
    b_oe_next = ~ddr_b_reg;
    e_oe_next = ~ddr_e_reg;
    if (cfg.ext_master) begin
      a_oe_next = 8'hFF;
      b_oe_next = 8'hFF;
      e_oe_next = 8'hFF;
    end else if (cfg.bus_en) begin
      e_oe_next = e_oe_next & ~ebm_pkg::EBM_E_CTRL_MASK;
      e_out_next[ebm_pkg::EBM_E_STB_BIT] = (phase_reg != ebm_pkg::EBM_PH_IDLE);
      e_out_next[ebm_pkg::EBM_E_RW_BIT] = ~req_reg.write;
      e_out_next[ebm_pkg::EBM_E_LSTRB_BIT] = cfg.wide;
      b_oe_next = 8'h00;
      unique case (phase_reg)
        ebm_pkg::EBM_PH_IDLE, ebm_pkg::EBM_PH_ADDR: begin
          a_out_next = req_reg.addr[15:8];
          b_out_next = req_reg.addr[7:0];
          a_oe_next = 8'h00;
        end
        ebm_pkg::EBM_PH_DATA: begin
          a_out_next = req_reg.wdata[15:8];
          b_out_next = cfg.wide ? req_reg.wdata[7:0] : req_reg.addr[7:0];
          a_oe_next = req_reg.write ? 8'h00 : 8'hFF;
          b_oe_next = (req_reg.write || !cfg.wide) ? 8'h00 : 8'hFF;
        end
        ebm_pkg::EBM_PH_DATA_LO: begin
          a_out_next = req_reg.wdata[7:0];
          b_out_next = req_reg.addr[7:0];
          a_oe_next = req_reg.write ? 8'h00 : 8'hFF;
        end
      endcase
    end
  end

  // pins registered
  // Port K always GPIO; all outputs come from flip-flops.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      port_a_out <= 8'h00;
      port_b_out <= 8'h00;
      port_e_out <= 8'h00;
      port_k_out <= 8'h00;
      port_a_oe_n <= 8'hFF;
      port_b_oe_n <= 8'hFF;
      port_e_oe_n <= 8'hFF;
      port_k_oe_n <= 8'hFF;
      cpu_active <= 1'b0;
      background_debug_mode <= 1'b0;
    end else begin
      port_a_out <= a_out_next;
      port_b_out <= b_out_next;
      port_e_out <= e_out_next;
      port_k_out <= gpio_k_reg;
      port_a_oe_n <= captured_reg ? a_oe_next : 8'hFF;
      port_b_oe_n <= captured_reg ? b_oe_next : 8'hFF;
      port_e_oe_n <= captured_reg ? e_oe_next : 8'hFF;
      port_k_oe_n <= ~ddr_k_reg;
      cpu_active <= captured_reg && cfg.cpu_active && !cfg.bdm_active;
      background_debug_mode <= captured_reg && cfg.bdm_active;
    end
  end

  // Assertions.
  a_bdm_no_bus: assert property (@(posedge clk_sys) disable iff (!rst_n)
    background_debug_mode |-> (port_a_oe_n == ~$past(ddr_a_reg))) else $error("bus in bdm");
  a_single_gpio: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (captured_reg && mode_reg == ebm_pkg::EBM_NORMAL_SINGLE) |=> (port_b_oe_n == ~$past(ddr_b_reg)))
    else $error("single-chip port b not gpio");
  a_wide_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (phase_reg == ebm_pkg::EBM_PH_ADDR && cfg.wide) |=> ##1 core_ack) else $error("wide ack late");
  a_narrow_ack: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (phase_reg == ebm_pkg::EBM_PH_ADDR && !cfg.wide) |=> !core_ack ##1 !core_ack ##1 core_ack)
    else $error("narrow ack wrong");
  a_test_prot: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (reg_wr && reg_addr == ebm_pkg::EBM_OFF_CTRL && !cfg.prot_lifted) |=> $stable(ctrl_reg))
    else $error("ctrl written while protected");
  a_periph_hiz: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (captured_reg && cfg.ext_master) |=> (port_a_oe_n == 8'hFF && !cpu_active))
    else $error("periph mode driving");
  a_mode_held: assert property (@(posedge clk_sys) disable iff (!rst_n)
    captured_reg |=> $stable(mode_reg)) else $error("mode changed after capture");
  a_ectl_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (captured_reg && cfg.bus_en && !cfg.ext_master) |=> (port_e_oe_n[ebm_pkg::EBM_E_STB_BIT] == 1'b0))
    else $error("port e control not driven");
  c_wide: cover property (@(posedge clk_sys) disable iff (!rst_n) core_ack && cfg.wide);
  c_narrow: cover property (@(posedge clk_sys) disable iff (!rst_n) core_ack && !cfg.wide);
  c_test_wr: cover property (@(posedge clk_sys) disable iff (!rst_n)
    reg_wr && reg_addr == ebm_pkg::EBM_OFF_CTRL && cfg.prot_lifted);

endmodule

// ==== inc/ebm_pkg.sv ====
/*
  Package for the external bus mode port configuration block.
  Assumes a single clock domain and an 8-bit register port.
*/
package ebm_pkg;

  // Operating modes captured at reset.
  typedef enum logic [2:0] {
    EBM_SPECIAL_SINGLE = 3'h0,
    EBM_SPECIAL_TEST   = 3'h1,
    EBM_SPECIAL_PERIPH = 3'h2,
    EBM_EMUL_NARROW    = 3'h3,
    EBM_NORMAL_SINGLE  = 3'h4,
    EBM_NORMAL_NARROW  = 3'h5,
    EBM_EMUL_WIDE      = 3'h6,
    EBM_NORMAL_WIDE    = 3'h7
  } ebm_mode_t;

  // Bus phases of the multiplexed external cycle.
  typedef enum logic [1:0] {
    EBM_PH_IDLE,
    EBM_PH_ADDR,
    EBM_PH_DATA,
    EBM_PH_DATA_LO
  } ebm_phase_t;

  // Port function assignment decoded from the mode.
  typedef struct packed {
    logic bus_en;
    logic wide;
    logic cpu_active;
    logic bdm_active;
    logic ext_master;
    logic prot_lifted;
  } ebm_portcfg_t;

  // External bus request from the core.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } ebm_req_t;

  // Register offsets.
  localparam logic [7:0] EBM_OFF_RSVD4 = 8'h04;
  localparam logic [7:0] EBM_OFF_RSVD5 = 8'h05;
  localparam logic [7:0] EBM_OFF_RSVD6 = 8'h06;
  localparam logic [7:0] EBM_OFF_RSVD7 = 8'h07;
  localparam logic [7:0] EBM_OFF_MODE = 8'h00;
  localparam logic [7:0] EBM_OFF_CTRL = 8'h01;
  localparam logic [7:0] EBM_OFF_GPIO_A = 8'h02;
  localparam logic [7:0] EBM_OFF_GPIO_B = 8'h03;
  localparam logic [7:0] EBM_OFF_DDR_A = 8'h08;
  localparam logic [7:0] EBM_OFF_DDR_B = 8'h09;
  localparam logic [7:0] EBM_OFF_GPIO_E = 8'h0A;
  localparam logic [7:0] EBM_OFF_DDR_E = 8'h0B;
  localparam logic [7:0] EBM_OFF_GPIO_K = 8'h0C;
  localparam logic [7:0] EBM_OFF_DDR_K = 8'h0D;

  // Field positions of the control register.
  localparam int EBM_CTRL_WIDE_BIT = 0;
  localparam int EBM_CTRL_BUSEN_BIT = 1;

  // Reset value and reserved-read value.
  localparam logic [7:0] EBM_RST_BYTE = 8'h00;
  localparam logic [7:0] EBM_RSVD_READ = 8'h00;

  // Port E pins kept for bus control in bus modes: strobe, read/write, low strobe.
  localparam logic [7:0] EBM_E_CTRL_MASK = 8'h1C;
  localparam int EBM_E_STB_BIT = 4;
  localparam int EBM_E_RW_BIT = 2;
  localparam int EBM_E_LSTRB_BIT = 3;

  // Bus cycle length in clock cycles per phase.
  localparam logic [1:0] EBM_PHASE_CYCLES = 2'h1;

endpackage

// ==== verif/ebm_ext_mem.sv ====
/*
  Behavioural external memory on the multiplexed bus of ports A and B.
  Assumes read cycles show the address on both ports with read/write high.
*/
`timescale 1ns/10ps
module ebm_ext_mem (
  // Clock.
  input wire logic clk_sys,
  // Bus pins from the device.
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] port_a_oe_n,
  input wire logic [7:0] port_b_out,
  input wire logic [7:0] port_b_oe_n,
  input wire logic [7:0] port_e_out,
  // Data returned to the device.
  output logic [7:0] port_a_in,
  output logic [7:0] port_b_in
);
  logic [15:0] addr_reg;
  logic [15:0] word;
  logic [7:0] idle_reg = 8'hA5;
  logic shown;
  // An address cycle drives both ports while read/write is high.
  assign shown = (port_a_oe_n == 8'h00) && (port_b_oe_n == 8'h00) &&
    port_e_out[ebm_pkg::EBM_E_RW_BIT];
  assign word = (shown ? {port_a_out, port_b_out} : addr_reg) ^ 16'h5A3C;
  // Latch the address; the idle pattern churns so stale data never looks valid.
  always_ff @(posedge clk_sys) begin
    if (shown) begin
      addr_reg <= {port_a_out, port_b_out};
    end
    idle_reg <= ~idle_reg;
  end
  always_comb begin
    port_a_in = idle_reg;
    port_b_in = ~idle_reg;
    if (port_e_out[ebm_pkg::EBM_E_RW_BIT]) begin
      port_a_in = (port_e_out[ebm_pkg::EBM_E_LSTRB_BIT] || shown) ? word[15:8] : word[7:0];
      port_b_in = word[7:0];
    end
  end
endmodule

// ==== verif/ebm_top_tb_top.sv ====
/*
  Self-checking testbench for the external bus mode port configuration block.
  Assumes the external memory model on ports A and B and a 100 MHz clock.
*/
`timescale 1ns/10ps
module ebm_top_tb_top;
  logic clk_sys;
  logic rst_n;
  logic [2:0] mode_pins;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic reg_wr, reg_rd, core_ack, cpu_active, background_debug_mode;
  ebm_pkg::ebm_req_t core_req;
  logic [15:0] core_rdata;
  logic [7:0] port_a_in, port_a_out, port_a_oe_n, port_b_in, port_b_out, port_b_oe_n;
  logic [7:0] port_e_in, port_e_out, port_e_oe_n, port_k_in, port_k_out, port_k_oe_n;
  int mismatches;
  int checks;
  int seed;
  // Bus, wide and processor-running flags indexed by mode code.
  logic [7:0] bus_tbl = 8'hEA;
  logic [7:0] wide_tbl = 8'hC2;
  logic [7:0] cpu_tbl = 8'hFA;

  // Device and far-side memory.
  ebm_top ebm_top_inst (
    .clk_sys(clk_sys), .rst_n(rst_n), .mode_pins(mode_pins), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .core_req(core_req), .core_ack(core_ack), .core_rdata(core_rdata),
    .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
    .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n),
    .port_e_in(port_e_in), .port_e_out(port_e_out), .port_e_oe_n(port_e_oe_n),
    .port_k_in(port_k_in), .port_k_out(port_k_out), .port_k_oe_n(port_k_oe_n),
    .cpu_active(cpu_active), .background_debug_mode(background_debug_mode));
  ebm_ext_mem ebm_ext_mem_inst (
    .clk_sys(clk_sys), .port_a_out(port_a_out), .port_a_oe_n(port_a_oe_n),
    .port_b_out(port_b_out), .port_b_oe_n(port_b_oe_n), .port_e_out(port_e_out),
    .port_a_in(port_a_in), .port_b_in(port_b_in));

  // Free-running 100 MHz clock.
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // Word the memory model returns for an address.
  function automatic logic [15:0] exp_word(input logic [15:0] a);
    return a ^ 16'h5A3C;
  endfunction

  // Acknowledge latency for a mode; zero means no acknowledge at all.
  function automatic int exp_lat(input logic [2:0] m);
    return !bus_tbl[m] ? 0 : (wide_tbl[m] ? 3 : 4);
  endfunction

  // Compares one value and reports a difference.
  task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Prints the verdict and stops the run.
  task automatic end_sim();
    if (mismatches == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // One-cycle register write.
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  // One-cycle register read; data taken in the following cycle.
  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  // Resets with a mode strap, then stops just after the second edge past release.
  task automatic start_mode(input logic [2:0] m);
    @(posedge clk_sys);
    rst_n <= 1'b0;
    mode_pins <= m;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask

  // Core request held until acknowledge or for at most eight cycles, counting cycles from the edge that presents it.
  task automatic bus_op(input logic wr, input logic [15:0] a, input int lat);
    int n;
    logic [15:0] wd;
    n = 0;
    wd = 16'($random(seed));
    @(posedge clk_sys);
    core_req <= '{valid: 1'b1, write: wr, addr: a, wdata: wd};
    while (n < 8 && core_ack !== 1'b1) begin
      @(posedge clk_sys);
      #1;
      n++;
      if (n == 2 && lat != 0) check("addr_pins", a, {port_a_out, port_b_out});
      if (n == 3 && wr && lat != 0) begin
        check("wdata_pins", {8'h0, wd[15:8]}, {8'h0, port_a_out});
      end
    end
    core_req.valid <= 1'b0;
    if (lat == 0) begin
      check("ack_absent", 16'h0, {15'h0, core_ack});
    end else begin
      check("ack_cycles", 16'(lat), 16'(n));
      if (!wr) check("core_rdata", exp_word(a), core_rdata);
      if (core_ack !== 1'b1) end_sim();
    end
    @(posedge clk_sys);
  endtask

  // General-purpose ports and register map in single-chip operation.
  task automatic gpio_test();
    logic [7:0] v, k, dk, d;
    v = 8'($random(seed));
    k = 8'($random(seed));
    dk = 8'($random(seed));
    port_k_in <= k;
    reg_write(ebm_pkg::EBM_OFF_DDR_A, 8'hFF);
    reg_write(ebm_pkg::EBM_OFF_GPIO_A, v);
    repeat (2) @(posedge clk_sys);
    #1;
    check("port_a_out", {8'h0, v}, {8'h0, port_a_out});
    check("port_a_oe_n", 16'h0, {8'h0, port_a_oe_n});
    reg_write(ebm_pkg::EBM_OFF_DDR_K, dk);
    reg_write(ebm_pkg::EBM_OFF_GPIO_K, v);
    reg_write(ebm_pkg::EBM_OFF_DDR_B, dk);
    reg_write(ebm_pkg::EBM_OFF_GPIO_B, k);
    reg_read(ebm_pkg::EBM_OFF_GPIO_K, d);
    check("gpio_k_read", {8'h0, (v & dk) | (k & ~dk)}, {8'h0, d});
    check("port_b_out", {8'h0, k}, {8'h0, port_b_out});
    check("port_b_oe_n", {8'h0, ~dk}, {8'h0, port_b_oe_n});
    check("port_k_out", {8'h0, v}, {8'h0, port_k_out});
    check("port_k_oe_n", {8'h0, ~dk}, {8'h0, port_k_oe_n});
    for (int o = 4; o < 8; o++) begin
      reg_write(8'(o), 8'hFF);
      reg_read(8'(o), d);
      check("reserved_read", 16'h0, {8'h0, d});
    end
    reg_read(8'h3F, d);
    check("unmapped_read", 16'h0, {8'h0, d});
    reg_write(ebm_pkg::EBM_OFF_MODE, 8'hFF);
    reg_read(ebm_pkg::EBM_OFF_MODE, d);
    check("mode_read_only", 16'h4, {8'h0, d});
  endtask

  // Full pass through one operating mode.
  task automatic mode_scenario(input logic [2:0] m);
    logic [7:0] d;
    logic [15:0] a;
    start_mode(m);
    check("bdm", {15'h0, m == 3'h0}, {15'h0, background_debug_mode});
    if (m != 3'h0) check("cpu_active", {15'h0, cpu_tbl[m]}, {15'h0, cpu_active});
    check("e_ctrl_oe_n", bus_tbl[m] ? 16'h0 : 16'h7, {13'h0, port_e_oe_n[4:2]});
    if (bus_tbl[m]) check("e_wide", {15'h0, wide_tbl[m]}, {15'h0, port_e_out[3]});
    if (!bus_tbl[m]) check("a_oe_n", 16'hFF, {8'h0, port_a_oe_n});
    reg_read(ebm_pkg::EBM_OFF_MODE, d);
    check("mode_reg", {13'h0, m}, {8'h0, d});
    repeat (2) begin
      a = 16'($random(seed));
      bus_op(1'b0, a, exp_lat(m));
    end
    bus_op(1'b1, 16'($random(seed)), exp_lat(m));
    if (m == 3'h4) gpio_test();
  endtask

  // Main sequence: every mode, then control-bit protection.
  initial begin
    seed = 32'hb0fd;
    rst_n = 1'b0;
    mode_pins = 3'h0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    core_req = '0;
    port_e_in = 8'h00;
    port_k_in = 8'h00;
    mismatches = 0;
    checks = 0;
    for (int m = 0; m < 8; m++) begin
      mode_scenario(3'(m));
    end
    start_mode(3'h1);
    reg_write(ebm_pkg::EBM_OFF_CTRL, 8'h01);
    bus_op(1'b0, 16'h1234, 4);
    reg_write(ebm_pkg::EBM_OFF_CTRL, 8'h02);
    bus_op(1'b0, 16'hFEDC, 0);
    start_mode(3'h7);
    reg_write(ebm_pkg::EBM_OFF_CTRL, 8'h03);
    bus_op(1'b0, 16'h0F0F, 3);
    end_sim();
  end
endmodule
